// ### src/pal_alarm_logic.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pal_consts.svh"
// Contract
// - Four alarms: FS high/low, deviation high/low, band
// - Alarm drives outputs, message and red beacon
// - Open sensor raises fault, forces safe output
// - RTD break when any of three wires open
// - Milliamp input never reports sensor break
// - Loop break if PV static after demand change
// - Remote fail after five seconds without setpoint
// - Hysteresis separates alarm on and off levels
// - Non-latching alarm clears when condition goes
// - Auto latch holds until ack; early ack accepted
// - Manual latch needs condition gone and ack
// - Manual latch ignores ack while condition present
// - Event mode drives output but not beacon
// - Event message shown only while condition holds
// - Blocking holds alarm until first safe state
// - Setpoint change re-arms blocking
// - Beacon flashes unacked, steady when acked active
// - Non-latching alarm resets if cleared before ack
module pal_alarm_logic
  import pal_pkg::*;
#(
  parameter int N_ALM = 4,
  parameter int DW    = 16,
  parameter longint unsigned RSP_TIMEOUT_CYC = longint'(`PAL_RSP_TIMEOUT_S) * `PAL_CLK_HZ,
  parameter int unsigned FLASH_HALF_CYC = `PAL_CLK_HZ / (2 * `PAL_FLASH_HZ)
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Operator and sensor
  input  wire logic              ack_pulse,
  input  wire pal_sensor_t       sensor,
  input  wire logic              rsp_strobe,
  // Indications
  output logic                   alarm_beacon,
  output logic                   message_on,
  output logic [N_ALM-1:0]       alarm_out,
  output logic                   sensor_break_code,
  output logic                   loop_break,
  output logic                   remote_fail,
  output logic [DW-1:0]          control_out
);
  localparam int RW = 40;

  logic                 [DW-1:0] process_value_reg;
  logic                 [DW-1:0] setpoint_value_reg;
  logic                 [DW-1:0] demand_reg;
  logic                 [DW-1:0] safe_reg;
  logic                 [31:0]   loop_dly_reg;
  logic                          rsp_en_reg;
  pal_cfg_t             [N_ALM-1:0] cfg_reg;
  logic [N_ALM-1:0]     [DW-1:0] thr_reg;
  logic [N_ALM-1:0]     [DW-1:0] hys_reg;
  logic [N_ALM-1:0]              active_reg;
  logic [N_ALM-1:0]              acked_reg;
  logic [N_ALM-1:0]              cond_reg;
  logic [N_ALM-1:0]              blocked_reg;
  logic [N_ALM-1:0]              cond_next;
  logic [N_ALM-1:0]              ev_cond;
  logic                          wr_en;
  logic                          rd_en;
  logic                          sp_write;
  logic                          sw_ack;
  logic                          ack_any;
  logic                          mapped;
  logic [31:0]                   rd_mux;

  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && penable && !pwrite;
  assign pready   = 1'b1;
  assign sp_write = wr_en && paddr == `PAL_OFF_SP && pwdata[DW-1:0] != setpoint_value_reg;
  assign sw_ack   = wr_en && paddr == `PAL_OFF_CTRL && pwdata[`PAL_CTRL_ACK_BIT];
  assign ack_any  = ack_pulse || sw_ack;

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      process_value_reg  <= '0;
      setpoint_value_reg <= '0;
      demand_reg         <= '0;
      safe_reg           <= `PAL_SAFE_RESET;
      loop_dly_reg       <= `PAL_LOOP_RESET;
      rsp_en_reg         <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        `PAL_OFF_PV:      process_value_reg  <= pwdata[DW-1:0];
        `PAL_OFF_SP:      setpoint_value_reg <= pwdata[DW-1:0];
        `PAL_OFF_DEMAND:  demand_reg         <= pwdata[DW-1:0];
        `PAL_OFF_SAFEOUT: safe_reg           <= pwdata[DW-1:0];
        `PAL_OFF_LOOPDLY: loop_dly_reg       <= pwdata;
        `PAL_OFF_CTRL:    rsp_en_reg         <= pwdata[`PAL_CTRL_RSPEN_BIT];
        default: ;
      endcase
    end
  end

  // Per-alarm evaluation
  genvar g;
  generate
    for (g = 0; g < N_ALM; g++) begin : g_alm
      localparam logic [11:0] BASE = 12'(`PAL_OFF_ALM_BASE + g * `PAL_ALM_STRIDE);
      logic signed [DW:0] pv;
      logic signed [DW:0] dev;
      logic signed [DW:0] mag;
      logic signed [DW:0] thr;
      logic signed [DW:0] on_lvl;
      logic signed [DW:0] off_lvl;
      logic signed [DW:0] off_lo;
      logic               trip;
      logic               clear;
      assign pv  = {1'b0, process_value_reg};
      assign dev = pv - $signed({1'b0, setpoint_value_reg});
      assign mag = dev[DW] ? -dev : dev;
      assign thr = {1'b0, thr_reg[g]};
      assign off_lvl = thr - $signed({1'b0, hys_reg[g]});
      assign off_lo  = thr + $signed({1'b0, hys_reg[g]});
      assign on_lvl  = thr;
      always_comb begin
        trip  = 1'b0;
        clear = 1'b1;
        unique case (cfg_reg[g].kind)
          PAL_FS_HI:  begin trip = pv > on_lvl;   clear = pv <= off_lvl; end
          PAL_FS_LO:  begin trip = pv < on_lvl;   clear = pv >= off_lo;  end
          PAL_DEV_HI: begin trip = dev > on_lvl;  clear = dev <= off_lvl; end
          PAL_DEV_LO: begin trip = dev < -on_lvl; clear = dev >= -off_lvl; end
          PAL_BAND:   begin trip = mag > on_lvl;  clear = mag <= off_lvl; end
          default:    begin trip = 1'b0;          clear = 1'b1; end
        endcase
        cond_next[g] = cond_reg[g] ? !clear : trip;
      end
      assign ev_cond[g] = cond_reg[g] && cfg_reg[g].latch == PAL_EVENT;

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cfg_reg[g] <= '0;
          thr_reg[g] <= '0;
          hys_reg[g] <= '0;
        end else if (wr_en) begin
          if (paddr == BASE + `PAL_ALM_CFG) begin
            cfg_reg[g].blocking <= pwdata[`PAL_CFG_BLOCK_BIT];
            cfg_reg[g].latch    <= pal_latch_t'(pwdata[`PAL_CFG_LATCH_LSB +: 2]);
            cfg_reg[g].kind     <= pal_type_t'(pwdata[`PAL_CFG_TYPE_LSB +: 3]);
          end
          if (paddr == BASE + `PAL_ALM_THR) thr_reg[g] <= pwdata[DW-1:0];
          if (paddr == BASE + `PAL_ALM_HYS) hys_reg[g] <= pwdata[DW-1:0];
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cond_reg[g]    <= 1'b0;
          blocked_reg[g] <= 1'b1;
        end else begin
          cond_reg[g] <= cond_next[g];
          if (sp_write && cfg_reg[g].blocking) blocked_reg[g] <= 1'b1;
          else if (!cond_next[g]) blocked_reg[g] <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          active_reg[g] <= 1'b0;
          acked_reg[g]  <= 1'b0;
        end else if (cond_reg[g] && !active_reg[g] && !(cfg_reg[g].blocking && blocked_reg[g])) begin
          active_reg[g] <= 1'b1;
          acked_reg[g]  <= 1'b0;
        end else if (active_reg[g]) begin
          unique case (cfg_reg[g].latch)
            PAL_NOLATCH, PAL_EVENT: begin
              if (!cond_reg[g]) active_reg[g] <= 1'b0;
              if (ack_any) acked_reg[g] <= 1'b1;
            end
            PAL_AUTO: begin
              if (ack_any) acked_reg[g] <= 1'b1;
              if (!cond_reg[g] && (acked_reg[g] || ack_any)) active_reg[g] <= 1'b0;
            end
            PAL_MANUAL: begin
              if (ack_any && !cond_reg[g]) begin
                active_reg[g] <= 1'b0;
                acked_reg[g]  <= 1'b1;
              end
            end
          endcase
        end
      end
      assign alarm_out[g] = active_reg[g];
    end
  endgenerate

  // Sensor break
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sensor_break_code <= 1'b0;
    else if (sensor.milliamp_mode) sensor_break_code <= 1'b0;
    else if (sensor.rtd_mode) sensor_break_code <= sensor.open_a | sensor.open_b | sensor.open_c;
    else sensor_break_code <= sensor.open_a;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) control_out <= '0;
    else control_out <= sensor_break_code ? safe_reg : demand_reg;
  end

  // Loop break watch
  logic [31:0]   loop_cnt_reg;
  logic          loop_armed_reg;
  logic [DW-1:0] pv_snap_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_cnt_reg   <= '0;
      loop_armed_reg <= 1'b0;
      pv_snap_reg    <= '0;
      loop_break     <= 1'b0;
    end else if (wr_en && paddr == `PAL_OFF_DEMAND && pwdata[DW-1:0] != demand_reg) begin
      loop_cnt_reg   <= '0;
      loop_armed_reg <= 1'b1;
      pv_snap_reg    <= process_value_reg;
      loop_break     <= 1'b0;
    end else if (loop_armed_reg) begin
      if (process_value_reg != pv_snap_reg) begin
        loop_armed_reg <= 1'b0;
        loop_break     <= 1'b0;
      end else if (loop_cnt_reg >= loop_dly_reg) begin
        loop_armed_reg <= 1'b0;
        loop_break     <= 1'b1;
      end else loop_cnt_reg <= loop_cnt_reg + 32'h0000_0001;
    end
  end

  // Remote setpoint watchdog
  logic [RW-1:0] rsp_cnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_cnt_reg <= '0;
      remote_fail <= 1'b0;
    end else if (!rsp_en_reg || rsp_strobe) begin
      rsp_cnt_reg <= '0;
      remote_fail <= 1'b0;
    end else if (rsp_cnt_reg >= RW'(RSP_TIMEOUT_CYC - 1)) begin
      remote_fail <= 1'b1;
    end else rsp_cnt_reg <= rsp_cnt_reg + RW'(1);
  end

  // Beacon flash divider
  logic [31:0] flash_cnt_reg;
  logic        flash_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_cnt_reg <= '0;
      flash_reg     <= 1'b0;
    end else if (flash_cnt_reg >= FLASH_HALF_CYC - 1) begin
      flash_cnt_reg <= '0;
      flash_reg     <= !flash_reg;
    end else flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
  end

  logic [N_ALM-1:0] beacon_src;
  logic             sys_alarm;
  always_comb begin
    for (int i = 0; i < N_ALM; i++) begin
      beacon_src[i] = active_reg[i] && cfg_reg[i].latch != PAL_EVENT;
    end
  end
  assign sys_alarm = sensor_break_code | loop_break | remote_fail;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_beacon <= 1'b0;
      message_on   <= 1'b0;
    end else begin
      if (|(beacon_src & ~acked_reg) || sys_alarm) alarm_beacon <= flash_reg;
      else alarm_beacon <= |beacon_src;
      message_on <= |beacon_src || |ev_cond || sys_alarm;
    end
  end

  // APB read
  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    unique case (paddr)
      `PAL_OFF_CTRL:    rd_mux = {29'h0, rsp_en_reg, 2'b00};
      `PAL_OFF_PV:      rd_mux = 32'(process_value_reg);
      `PAL_OFF_SP:      rd_mux = 32'(setpoint_value_reg);
      `PAL_OFF_STATUS:  rd_mux = {13'h0, remote_fail, loop_break, sensor_break_code,
                                  4'(blocked_reg), 4'(acked_reg), 4'(cond_reg), 4'(active_reg)};
      `PAL_OFF_LOOPDLY: rd_mux = loop_dly_reg;
      `PAL_OFF_SAFEOUT: rd_mux = 32'(safe_reg);
      `PAL_OFF_DEMAND:  rd_mux = 32'(demand_reg);
      `PAL_OFF_OUTPUT:  rd_mux = 32'(control_out);
      default: begin
        mapped = 1'b0;
        for (int i = 0; i < N_ALM; i++) begin
          if (paddr == 12'(`PAL_OFF_ALM_BASE + i * `PAL_ALM_STRIDE + `PAL_ALM_CFG)) begin
            rd_mux[`PAL_CFG_TYPE_LSB +: 3]  = cfg_reg[i].kind;
            rd_mux[`PAL_CFG_LATCH_LSB +: 2] = cfg_reg[i].latch;
            rd_mux[`PAL_CFG_BLOCK_BIT]      = cfg_reg[i].blocking;
            mapped = 1'b1;
          end
          if (paddr == 12'(`PAL_OFF_ALM_BASE + i * `PAL_ALM_STRIDE + `PAL_ALM_THR)) begin
            rd_mux = 32'(thr_reg[i]);
            mapped = 1'b1;
          end
          if (paddr == 12'(`PAL_OFF_ALM_BASE + i * `PAL_ALM_STRIDE + `PAL_ALM_HYS)) begin
            rd_mux = 32'(hys_reg[i]);
            mapped = 1'b1;
          end
        end
      end
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) prdata <= '0;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end

  // Assertions
  a_mamp_no_break: assert property (@(posedge clk) disable iff (rst)
    sensor.milliamp_mode |=> !sensor_break_code) else $error("break in mA mode");
  a_rtd_wire_break: assert property (@(posedge clk) disable iff (rst)
    (sensor.rtd_mode && !sensor.milliamp_mode && sensor.open_b) |=> sensor_break_code)
    else $error("rtd wire missed");
  a_safe_output: assert property (@(posedge clk) disable iff (rst)
    sensor_break_code && $stable(safe_reg) |=> control_out == $past(safe_reg)) else $error("safe level");
  a_nolatch_clear: assert property (@(posedge clk) disable iff (rst)
    active_reg[0] && !cond_reg[0] && cfg_reg[0].latch == PAL_NOLATCH |=> !active_reg[0])
    else $error("nolatch stuck");
  a_manual_hold: assert property (@(posedge clk) disable iff (rst)
    active_reg[0] && cond_reg[0] && cfg_reg[0].latch == PAL_MANUAL |=> active_reg[0])
    else $error("manual cleared early");
  a_auto_hold: assert property (@(posedge clk) disable iff (rst)
    active_reg[0] && !acked_reg[0] && !ack_any && cfg_reg[0].latch == PAL_AUTO |=> active_reg[0])
    else $error("auto cleared unacked");
  a_block_hold: assert property (@(posedge clk) disable iff (rst)
    !active_reg[0] && blocked_reg[0] && cfg_reg[0].blocking |=> !active_reg[0])
    else $error("blocked alarm fired");
  a_sp_rearm: assert property (@(posedge clk) disable iff (rst)
    sp_write && cfg_reg[0].blocking |=> blocked_reg[0]) else $error("no rearm");
  a_event_dark: assert property (@(posedge clk) disable iff (rst)
    (cfg_reg[N_ALM-1].latch == PAL_EVENT && active_reg == {1'b1, {(N_ALM-1){1'b0}}} && !sys_alarm) [*2]
    |-> !alarm_beacon) else $error("event lit beacon");
  a_remote_fail: assert property (@(posedge clk) disable iff (rst)
    remote_fail && rsp_en_reg |-> !$past(rsp_strobe)) else $error("fail right after strobe");
endmodule // pal_alarm_logic
`default_nettype wire

// ### src/pal_consts.svh
`ifndef PAL_CONSTS_SVH
`define PAL_CONSTS_SVH
// Register byte offsets
`define PAL_OFF_CTRL      12'h000
`define PAL_OFF_PV        12'h004
`define PAL_OFF_SP        12'h008
`define PAL_OFF_STATUS    12'h00C
`define PAL_OFF_LOOPDLY   12'h010
`define PAL_OFF_SAFEOUT   12'h014
`define PAL_OFF_DEMAND    12'h018
`define PAL_OFF_OUTPUT    12'h01C
`define PAL_OFF_RSP       12'h020
`define PAL_OFF_ALM_BASE  12'h040
// Per-alarm block: config, threshold, hysteresis
`define PAL_ALM_STRIDE    12'h010
`define PAL_ALM_CFG       12'h000
`define PAL_ALM_THR       12'h004
`define PAL_ALM_HYS       12'h008
// Alarm config fields
`define PAL_CFG_TYPE_LSB  0
`define PAL_CFG_LATCH_LSB 4
`define PAL_CFG_BLOCK_BIT 8
// Control fields
`define PAL_CTRL_ACK_BIT  0
`define PAL_CTRL_MA_BIT   1
`define PAL_CTRL_RSPEN_BIT 2
// Timing and reset values
`define PAL_CLK_HZ        250000000
`define PAL_RSP_TIMEOUT_S 5
`define PAL_FLASH_HZ      2
`define PAL_SAFE_RESET    16'h0000
`define PAL_LOOP_RESET    32'h0000_1000
`endif

// ### src/pal_pkg.sv
package pal_pkg;
  typedef enum logic [2:0] {
    PAL_NONE = 3'b000, PAL_FS_HI = 3'b001, PAL_FS_LO = 3'b010,
    PAL_DEV_HI = 3'b011, PAL_DEV_LO = 3'b100, PAL_BAND = 3'b101
  } pal_type_t;
  typedef enum logic [1:0] {
    PAL_NOLATCH = 2'b00, PAL_AUTO = 2'b01, PAL_MANUAL = 2'b10, PAL_EVENT = 2'b11
  } pal_latch_t;
  typedef struct packed {
    logic       blocking;
    pal_latch_t latch;
    pal_type_t  kind;
  } pal_cfg_t;
  typedef struct packed {
    logic        open_a;
    logic        open_b;
    logic        open_c;
    logic        milliamp_mode;
    logic        rtd_mode;
  } pal_sensor_t;
endpackage

// ### test/pal_operator_model.sv
`timescale 1ns/1ps
`default_nettype none
module pal_operator_model #(
  parameter int N_ALM = 4
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Bench side
  input  wire logic             ack_req,
  output logic [N_ALM-1:0]      relay_on,
  // Device side
  input  wire logic [N_ALM-1:0] alarm_out,
  output logic                  ack_pulse
);
  logic seen_reg;
  // Each toggle of the request gives one single-cycle pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_reg  <= 1'b0;
      ack_pulse <= 1'b0;
    end else begin
      seen_reg  <= ack_req;
      ack_pulse <= ack_req ^ seen_reg;
    end
  end
  // Relays follow the alarm drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) relay_on <= '0;
    else relay_on <= alarm_out;
  end
endmodule // pal_operator_model
`default_nettype wire

// ### test/test_pal_alarm_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "pal_consts.svh"
module test_pal_alarm_logic;
  import pal_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ack_req = 1'b0;
  logic        ack_pulse;
  pal_sensor_t sensor = '0;
  logic        rsp_strobe = 1'b0;
  logic        alarm_beacon;
  logic        message_on;
  logic [3:0]  alarm_out;
  logic [3:0]  relay_on;
  logic        sensor_break_code;
  logic        loop_break;
  logic        remote_fail;
  logic [15:0] control_out;
  logic [31:0] rdat;
  logic        rerr;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          tg;
  int          hi;

  pal_alarm_logic #(.RSP_TIMEOUT_CYC(50), .FLASH_HALF_CYC(4)) dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ack_pulse(ack_pulse), .sensor(sensor), .rsp_strobe(rsp_strobe),
    .alarm_beacon(alarm_beacon), .message_on(message_on), .alarm_out(alarm_out),
    .sensor_break_code(sensor_break_code), .loop_break(loop_break), .remote_fail(remote_fail),
    .control_out(control_out));
  pal_operator_model #(.N_ALM(4)) op (.clk(clk), .rst(rst), .ack_req(ack_req), .relay_on(relay_on),
    .alarm_out(alarm_out), .ack_pulse(ack_pulse));

  always #2 clk = ~clk;

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string m, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic b(input string m, input logic g, input logic e);
    chk(m, {31'h0, g}, {31'h0, e});
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic pv(input logic [31:0] v);
    wr(`PAL_OFF_PV, v);
    w(5);
  endtask
  task automatic ack();
    ack_req <= ~ack_req;
    w(5);
  endtask
  task automatic cfg(input int i, input logic [31:0] c, input logic [31:0] t, input logic [31:0] h);
    logic [11:0] a;
    a = `PAL_OFF_ALM_BASE + 12'(i) * `PAL_ALM_STRIDE;
    wr(a + `PAL_ALM_CFG, c);
    wr(a + `PAL_ALM_THR, t);
    wr(a + `PAL_ALM_HYS, h);
  endtask
  function automatic logic [31:0] cf(input logic bk, input pal_latch_t l, input pal_type_t t);
    return {23'h0, bk, 2'b00, l, 1'b0, t};
  endfunction
  task automatic watch();
    logic last;
    tg = 0;
    hi = 0;
    last = alarm_beacon;
    repeat (12) begin
      @(posedge clk);
      if (alarm_beacon !== last) tg++;
      if (alarm_beacon === 1'b1) hi++;
      last = alarm_beacon;
    end
  endtask

  task automatic t_regs();
    apb(1'b0, `PAL_OFF_LOOPDLY, '0);
    chk("loop delay reset", rdat, `PAL_LOOP_RESET);
    b("ready", pready, 1'b1);
    wr(12'(`PAL_OFF_ALM_BASE + 3 * `PAL_ALM_STRIDE), cf(1'b1, PAL_MANUAL, PAL_BAND));
    apb(1'b0, 12'(`PAL_OFF_ALM_BASE + 3 * `PAL_ALM_STRIDE), '0);
    chk("cfg readback", rdat, cf(1'b1, PAL_MANUAL, PAL_BAND));
    cfg(3, 0, 0, 0);
    apb(1'b0, 12'h0FC, '0);
    b("unmapped error", rerr, 1'b1);
    chk("unmapped data", rdat, '0);
  endtask
  task automatic t_block();
    pv(100);
    wr(`PAL_OFF_SP, 100);
    cfg(0, cf(1'b1, PAL_NOLATCH, PAL_DEV_HI), 20, 0);
    wr(`PAL_OFF_SP, 70);
    w(5);
    b("blocked", alarm_out[0], 1'b0);
    pv(85);
    pv(100);
    b("unblocked", alarm_out[0], 1'b1);
    pv(85);
    b("self clear", alarm_out[0], 1'b0);
    cfg(0, 0, 0, 0);
  endtask
  task automatic t_hys();
    cfg(0, cf(1'b0, PAL_NOLATCH, PAL_FS_HI), 100, 10);
    pv(101);
    b("fs high", alarm_out[0], 1'b1);
    b("relay", relay_on[0], 1'b1);
    watch();
    b("flash", tg >= 2, 1'b1);
    pv(95);
    b("hyst hold", alarm_out[0], 1'b1);
    pv(85);
    b("unacked reset", alarm_out[0], 1'b0);
    pv(101);
    ack();
    watch();
    chk("steady", hi, 12);
    pv(85);
    b("beacon off", alarm_beacon, 1'b0);
    cfg(0, 0, 0, 0);
  endtask
  task automatic t_auto();
    cfg(1, cf(1'b0, PAL_AUTO, PAL_FS_LO), 50, 0);
    pv(40);
    pv(60);
    b("auto held", alarm_out[1], 1'b1);
    ack();
    b("auto acked", alarm_out[1], 1'b0);
    pv(40);
    ack();
    b("early ack", alarm_out[1], 1'b1);
    pv(60);
    b("early ack clr", alarm_out[1], 1'b0);
    cfg(1, 0, 0, 0);
  endtask
  task automatic t_man();
    wr(`PAL_OFF_SP, 200);
    cfg(2, cf(1'b0, PAL_MANUAL, PAL_DEV_HI), 20, 0);
    pv(215);
    b("dev below", alarm_out[2], 1'b0);
    pv(230);
    b("dev above", alarm_out[2], 1'b1);
    ack();
    pv(200);
    b("early ack off", alarm_out[2], 1'b1);
    ack();
    b("manual clr", alarm_out[2], 1'b0);
    cfg(2, cf(1'b0, PAL_NOLATCH, PAL_DEV_LO), 20, 5);
    pv(175);
    b("dev low", alarm_out[2], 1'b1);
    wr(`PAL_OFF_CTRL, 32'h0000_0001);
    apb(1'b0, `PAL_OFF_STATUS, '0);
    chk("status", rdat & 32'h0007_0444, 32'h0000_0444);
    pv(183);
    b("dev low hold", alarm_out[2], 1'b1);
    pv(186);
    b("dev low clr", alarm_out[2], 1'b0);
    cfg(2, 0, 0, 0);
  endtask
  task automatic t_event();
    logic [31:0] pvs[4] = '{160, 215, 240, 200};
    logic        exp_on[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    cfg(3, cf(1'b0, PAL_EVENT, PAL_BAND), 30, 0);
    for (int i = 0; i < 4; i++) begin
      pv(pvs[i]);
      b("band out", alarm_out[3], exp_on[i]);
      b("event msg", message_on, exp_on[i]);
      b("no beacon", alarm_beacon, 1'b0);
    end
    cfg(3, 0, 0, 0);
  endtask
  task automatic t_loop();
    wr(`PAL_OFF_LOOPDLY, 20);
    wr(`PAL_OFF_DEMAND, 32'h0000_0011);
    w(10);
    b("loop early", loop_break, 1'b0);
    w(20);
    b("loop break", loop_break, 1'b1);
  endtask
  task automatic t_remote();
    wr(`PAL_OFF_CTRL, 32'h0000_0004);
    repeat (5) begin
      rsp_strobe <= 1'b1;
      @(posedge clk);
      rsp_strobe <= 1'b0;
      w(30);
      b("remote ok", remote_fail, 1'b0);
    end
    w(40);
    b("remote fail", remote_fail, 1'b1);
  endtask
  task automatic t_sensor();
    wr(`PAL_OFF_SAFEOUT, 32'h0000_0055);
    wr(`PAL_OFF_DEMAND, 32'h0000_0033);
    for (int i = 0; i < 3; i++) begin
      sensor <= '{open_a: i == 0, open_b: i == 1, open_c: i == 2, milliamp_mode: 1'b0, rtd_mode: 1'b1};
      w(5);
      b("rtd break", sensor_break_code, 1'b1);
      chk("safe out", {16'h0, control_out}, 32'h0000_0055);
      sensor <= '{default: 1'b0, rtd_mode: 1'b1};
      w(5);
      chk("demand out", {16'h0, control_out}, 32'h0000_0033);
    end
    sensor <= '{default: 1'b0, open_a: 1'b1, milliamp_mode: 1'b1};
    w(5);
    b("ma no break", sensor_break_code, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_block();
    t_hys();
    t_auto();
    t_man();
    t_event();
    t_loop();
    t_remote();
    t_sensor();
    results();
  end
endmodule // test_pal_alarm_logic
`default_nettype wire
